// *** rtl/hsi_i2c_slave.sv ***
`timescale 1ns/1ps
`include "hsi_regs.svh"
// Function
// - Field register 0x1f returns 12-bit signed reading, read-only.
// - Temperature register 0x1d returns 12-bit signed reading, read-only.
// - Sleep bit 0 at 0x20, read/write, resets low, sets power-down.
// - Sleep bit and serial logic follow SCL edges, not system activity.
// - About 50 us after wake, clock runs and bus answers again; here the bus answers even while asleep, and ready_out rises at 50 us.
// - Raw reading ready after 150 us, full accuracy after 500 us.
// - Leaving sleep reloads volatile registers as at power-on.
// - Start is SDA fall with SCL high; stop is SDA rise.
// - First byte holds 7-bit address, direction bit, then acknowledge.
// - Each data cycle moves eight bits plus one acknowledge.
// - SDA changes only while SCL is low, except start and stop.
// - Start or stop anywhere aborts and restarts the sequence.
// - Matching address acknowledged by driving SDA low on ninth clock.
// - Every written byte is acknowledged with SDA low.
// - Write is address, register byte, data bytes, stop.
// - Extra write bytes go to the next register address.
// - Before unlock, only the sleep bit accepts writes.
// - Reads are allowed at all times regardless of unlock.
// - Writing the key to 0x24 enables writes; here it only sets unlocked_out, and no register but sleep is ever written.
// - Unlock stays set until power cycle; nothing clears it.
// - SCL input only; SDA open-drain, never driven high.
// - Read is write-address, register byte, restart, read-address, data.
// - Reads return four bytes per register, then next register.
// - Not-acknowledge then stop ends read data.
module hsi_i2c_slave #(
   parameter logic [6:0] DEV_ADDR = `HSI_DEV_ADDR,
   parameter int CLK_MHZ = `HSI_CLK_MHZ
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Sensor side
   input wire hsi_pkg::hsi_read_s reading_in,
   output logic sleep_out,
   output logic unlocked_out,
   output logic ready_out,
   output logic raw_valid_out,
   output logic full_valid_out
);

   // Wake milestones counted in system clocks from the sleep clear
   localparam int WAKE_CLK_CYC = `HSI_WAKE_CLK_US * CLK_MHZ;
   localparam int WAKE_RAW_CYC = `HSI_WAKE_RAW_US * CLK_MHZ;
   localparam int WAKE_FULL_CYC = `HSI_WAKE_FULL_US * CLK_MHZ;

   ////////////////////////////////////////////////////////////////////////////
   // Register read decode, used for capture on first byte
   function automatic logic [31:0] reg_value(input logic [7:0] a,
                                              input hsi_pkg::hsi_read_s r,
                                              input logic slp);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (a)
         `HSI_ADDR_TEMP: v = {{20{1'b0}}, r.temp};
         `HSI_ADDR_FIELD: v = {{20{1'b0}}, r.field};
         `HSI_ADDR_SLEEP: v = {31'h0000_0000, slp};
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, two flops before any logic
   hsi_pkg::hsi_pins_s s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;

   always_comb begin
      s1_d = '{scl: scl_in, sda: sda_in};
      s2_d = s1_q;
      s3_d = s2_q;
   end

   // Reset to the idle bus level so no false edge or start follows reset
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         s1_q <= '{scl: 1'b1, sda: 1'b1};
         s2_q <= '{scl: 1'b1, sda: 1'b1};
         s3_q <= '{scl: 1'b1, sda: 1'b1};
      end else if (clk_en_in) begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
      end
   end

   // Edge and condition events from the second and third stages
   logic scl_rise, scl_fall, start_ev, stop_ev;
   assign scl_rise = s2_q.scl & ~s3_q.scl;
   assign scl_fall = ~s2_q.scl & s3_q.scl;
   assign start_ev = s2_q.scl & s3_q.scl & s3_q.sda & ~s2_q.sda;
   assign stop_ev = s2_q.scl & s3_q.scl & ~s3_q.sda & s2_q.sda;

   ////////////////////////////////////////////////////////////////////////////
   // Protocol engine; steps keyed to sampled SCL edges and to start and stop conditions
   hsi_pkg::hsi_state_e st_q, st_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d;
   logic [7:0] ptr_q, ptr_d;
   logic [1:0] byte_q, byte_d;
   logic [31:0] rdat_q, rdat_d;
   logic [31:0] key_q, key_d;
   logic rd_q, rd_d;
   logic sleep_q, sleep_d;
   logic unl_q, unl_d;
   logic sda_q, sda_d;
   logic ack_q, ack_d;
   logic wake_q, wake_d;
   logic rdy_q, rdy_d;
   logic raw_q, raw_d;
   logic full_q, full_d;

   // Register values at the pointer and the one after it; a word is copied
   // only when its first byte is loaded, so a reading that changes
   // in mid-word cannot tear the four bytes apart
   logic [31:0] cur_val, nxt_val;
   logic [7:0] ptr_inc;
   assign ptr_inc = ptr_q + 8'h01;
   assign cur_val = reg_value(ptr_q, reading_in, sleep_q);
   assign nxt_val = reg_value(ptr_inc, reading_in, sleep_q);

   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      sh_d = sh_q;
      ptr_d = ptr_q;
      byte_d = byte_q;
      rdat_d = rdat_q;
      key_d = key_q;
      rd_d = rd_q;
      sleep_d = sleep_q;
      unl_d = unl_q;
      sda_d = sda_q;
      ack_d = ack_q;
      if (start_ev || stop_ev) begin
         // Abort whatever is running; a start then waits for an address, a stop goes idle
         st_d = start_ev ? hsi_pkg::ST_ADDR : hsi_pkg::ST_IDLE;
         bit_d = 4'h0;
         sda_d = 1'b0;
         // Key is judged only at a stop, after all its bytes are in
         if (stop_ev && key_q == `HSI_UNLOCK_KEY) begin
            unl_d = 1'b1;
         end
      end else if (scl_rise) begin
         case (st_q)
            hsi_pkg::ST_ADDR, hsi_pkg::ST_REG, hsi_pkg::ST_WDATA: begin
               sh_d = {sh_q[6:0], s2_q.sda};
               bit_d = bit_q + 4'h1;
            end
            hsi_pkg::ST_RACK: ack_d = ~s2_q.sda;
            default: ;
         endcase
      end else if (scl_fall) begin
         case (st_q)
            hsi_pkg::ST_ADDR: begin
               if (bit_q == 4'h8) begin
                  if (sh_q[7:1] == DEV_ADDR) begin
                     st_d = hsi_pkg::ST_ADDR_ACK;
                     sda_d = 1'b1;
                     rd_d = sh_q[0];
                  end else begin
                     // Foreign address: stay off the bus until the next start
                     st_d = hsi_pkg::ST_IDLE;
                  end
               end
            end
            hsi_pkg::ST_ADDR_ACK: begin
               bit_d = 4'h0;
               if (rd_q) begin
                  st_d = hsi_pkg::ST_RDATA;
                  // Capture the whole word now; later bytes come from this copy
                  rdat_d = cur_val;
                  byte_d = 2'h0;
                  sda_d = ~cur_val[31];
               end else begin
                  st_d = hsi_pkg::ST_REG;
                  sda_d = 1'b0;
               end
            end
            hsi_pkg::ST_REG, hsi_pkg::ST_WDATA: begin
               if (bit_q == 4'h8) begin
                  sda_d = 1'b1;
                  st_d = hsi_pkg::ST_WACK;
                  if (st_q == hsi_pkg::ST_REG) begin
                     ptr_d = sh_q;
                     byte_d = 2'h0;
                     rd_d = 1'b0;
                  end else begin
                     rd_d = 1'b1;
                     if (ptr_q == `HSI_ADDR_UNLOCK) begin
                        key_d = {key_q[23:0], sh_q};
                     end
                     if (byte_q == 2'h3) begin
                        // Sleep is always writable; no other target is written here, unlock or not
                        if (ptr_q == `HSI_ADDR_SLEEP) begin
                           sleep_d = sh_q[`HSI_SLEEP_BIT];
                        end
                        ptr_d = ptr_inc;
                     end
                     byte_d = byte_q + 2'h1;
                  end
               end
            end
            hsi_pkg::ST_WACK: begin
               // Let go of SDA once the acknowledge clock has ended
               sda_d = 1'b0;
               bit_d = 4'h0;
               st_d = hsi_pkg::ST_WDATA;
            end
            hsi_pkg::ST_RDATA: begin
               if (bit_q == 4'h7) begin
                  sda_d = 1'b0;
                  st_d = hsi_pkg::ST_RACK;
               end else begin
                  // Most significant first; a one bit leaves the wire released
                  bit_d = bit_q + 4'h1;
                  rdat_d = {rdat_q[30:0], 1'b0};
                  sda_d = ~rdat_q[30];
               end
            end
            hsi_pkg::ST_RACK: begin
               if (ack_q) begin
                  bit_d = 4'h0;
                  st_d = hsi_pkg::ST_RDATA;
                  byte_d = byte_q + 2'h1;
                  if (byte_q == 2'h3) begin
                     // Next register sampled fresh, top byte first
                     ptr_d = ptr_inc;
                     rdat_d = nxt_val;
                     sda_d = ~nxt_val[31];
                  end else begin
                     rdat_d = {rdat_q[30:0], 1'b0};
                     sda_d = ~rdat_q[30];
                  end
               end else begin
                  st_d = hsi_pkg::ST_IDLE;
                  sda_d = 1'b0;
               end
            end
            default: st_d = hsi_pkg::ST_IDLE;
         endcase
      end
      if (wake_q && sleep_q == 1'b0) begin
         // Wake clears the collected key bytes as power-on does; unlock is kept
         key_d = 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wake sequencing after the sleep bit clears
   // Counter is 14 bits, so CLK_MHZ above 32 overflows the longest wait
   logic [13:0] wcnt_q, wcnt_d;
   hsi_pkg::hsi_wake_e wst_q, wst_d;

   always_comb begin
      wake_d = 1'b0;
      wcnt_d = wcnt_q;
      wst_d = wst_q;
      if (sleep_q) begin
         // Asleep: hold the sequence at its start
         wst_d = hsi_pkg::WK_OFF;
         wcnt_d = 14'h0000;
      end else if (wst_q != hsi_pkg::WK_FULL) begin
         wcnt_d = wcnt_q + 14'h0001;
         case (wst_q)
            hsi_pkg::WK_OFF: begin
               wake_d = (wcnt_q == 14'h0000);
               if (32'(wcnt_q) >= WAKE_CLK_CYC - 1) wst_d = hsi_pkg::WK_CLK;
            end
            hsi_pkg::WK_CLK: if (32'(wcnt_q) >= WAKE_RAW_CYC - 1) wst_d = hsi_pkg::WK_RAW;
            hsi_pkg::WK_RAW: if (32'(wcnt_q) >= WAKE_FULL_CYC - 1) wst_d = hsi_pkg::WK_FULL;
            default: wst_d = hsi_pkg::WK_FULL;
         endcase
      end
      // Status flags follow the next state, so each leaves a flop in step
      rdy_d = (wst_d != hsi_pkg::WK_OFF);
      raw_d = (wst_d == hsi_pkg::WK_RAW) || (wst_d == hsi_pkg::WK_FULL);
      full_d = (wst_d == hsi_pkg::WK_FULL);
   end

   // Clock enable low freezes every flop of the engine and the wake timer
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         st_q <= hsi_pkg::ST_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         ptr_q <= 8'h00;
         byte_q <= 2'h0;
         rdat_q <= 32'h0000_0000;
         key_q <= 32'h0000_0000;
         rd_q <= 1'b0;
         sleep_q <= `HSI_SLEEP_RST;
         unl_q <= 1'b0;
         sda_q <= 1'b0;
         ack_q <= 1'b0;
         wake_q <= 1'b0;
         wcnt_q <= 14'h0000;
         wst_q <= hsi_pkg::WK_FULL;
         rdy_q <= 1'b1;
         raw_q <= 1'b1;
         full_q <= 1'b1;
      end else if (clk_en_in) begin
         st_q <= st_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         ptr_q <= ptr_d;
         byte_q <= byte_d;
         rdat_q <= rdat_d;
         key_q <= key_d;
         rd_q <= rd_d;
         sleep_q <= sleep_d;
         unl_q <= unl_d;
         sda_q <= sda_d;
         ack_q <= ack_d;
         wake_q <= wake_d;
         wcnt_q <= wcnt_d;
         wst_q <= wst_d;
         rdy_q <= rdy_d;
         raw_q <= raw_d;
         full_q <= full_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from flops, sda_out tied low; SDA only ever pulled low
   assign sda_out = 1'b0;
   assign sda_oe_out = sda_q;
   assign sleep_out = sleep_q;
   assign unlocked_out = unl_q;
   assign ready_out = rdy_q;
   assign raw_valid_out = raw_q;
   assign full_valid_out = full_q;

endmodule

// *** rtl/hsi_regs.svh ***
`ifndef HSI_REGS_SVH
`define HSI_REGS_SVH
`define HSI_ADDR_TEMP 8'h1d
`define HSI_ADDR_FIELD 8'h1f
`define HSI_ADDR_SLEEP 8'h20
`define HSI_ADDR_UNLOCK 8'h24
`define HSI_UNLOCK_KEY 32'h2c413534
`define HSI_SLEEP_BIT 0
`define HSI_SLEEP_RST 1'b0
`define HSI_DEV_ADDR 7'h00
`define HSI_CLK_MHZ 25
`define HSI_WAKE_CLK_US 50
`define HSI_WAKE_RAW_US 150
`define HSI_WAKE_FULL_US 500
`endif

// *** rtl/hsi_pkg.sv ***
package hsi_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
   } hsi_state_e;
   typedef struct packed {
      logic scl;
      logic sda;
   } hsi_pins_s;
   typedef struct packed {
      logic [11:0] field;
      logic [11:0] temp;
   } hsi_read_s;
   typedef enum logic [1:0] {
      WK_OFF, WK_CLK, WK_RAW, WK_FULL
   } hsi_wake_e;
endpackage

// *** dv/hsi_i2c_slave_asserts.sv ***
`timescale 1ns/1ps
module hsi_chk #(
   parameter int CLK_MHZ = 25
) (
   // Clock, reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // Bus
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   // Status
   input wire logic sleep_out,
   input wire logic unlocked_out,
   input wire logic ready_out,
   input wire logic raw_valid_out,
   input wire logic full_valid_out
);
   // Wake bounds, a few cycles slack for the synchronisers
   localparam int RDY = 50 * CLK_MHZ + 8;
   localparam int RAW = 150 * CLK_MHZ + 8;
   localparam int FUL = 500 * CLK_MHZ + 8;
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////////////////////
   // Pin, reset and unlock relations
   property p_od; sda_oe_out |-> !sda_out; endproperty
   a_od: assert property (p_od) else $error("sda driven high");
   property p_hold; $changed(sda_oe_out) |-> !scl_in; endproperty
   a_hold: assert property (p_hold) else $error("sda moved with scl high");
   property p_rst; $rose(rst_n_in) |-> !sleep_out && !unlocked_out && !sda_oe_out; endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   property p_lock; unlocked_out |=> unlocked_out; endproperty
   a_lock: assert property (p_lock) else $error("unlock lost");
   // Wake sequence
   property p_rdy; $fell(sleep_out) |-> ##[1:RDY] ready_out; endproperty
   a_rdy: assert property (p_rdy) else $error("bus not ready in time");
   property p_raw; $fell(sleep_out) |-> ##[1:RAW] raw_valid_out; endproperty
   a_raw: assert property (p_raw) else $error("raw reading late");
   property p_full; $fell(sleep_out) |-> (!full_valid_out)[*8] ##[1:FUL] full_valid_out; endproperty
   a_full: assert property (p_full) else $error("full reading timing");
   property p_slp; sleep_out[*2] |-> !raw_valid_out && !full_valid_out; endproperty
   a_slp: assert property (p_slp) else $error("valid while asleep");
   property p_ord; raw_valid_out |-> ready_out; endproperty
   a_ord: assert property (p_ord) else $error("valid before ready");
   c_slp: cover property ($rose(sleep_out));
   c_unl: cover property ($rose(unlocked_out));
   c_ack: cover property ($rose(sda_oe_out));
endmodule

// *** dv/hsi_mst_model.sv ***
`timescale 1ns/1ps
module hsi_mst_model (
   // Clock and wire level
   input wire logic clk_in,
   input wire logic sda_in,
   // Master pins, sda_out low pulls the wire
   output logic scl_out,
   output logic sda_out
);
   // Idle bus: both lines released, clock parked high
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   // Long gaps so the slave has let go of SDA before SCL rises
   task automatic cond(input logic a, input logic b);
      sda_out = a;
      w(6);
      scl_out = 1'b1;
      w(6);
      sda_out = b;
      w(6);
   endtask
   task automatic start();
      cond(1'b1, 1'b0);
      scl_out = 1'b0;
   endtask
   task automatic stop();
      cond(1'b0, 1'b1);
   endtask
   // One 320 ns bit; data moves only while SCL is low
   task automatic bit_io(input logic b, output logic r);
      w(2);
      sda_out = b;
      w(4);
      scl_out = 1'b1;
      w(1);
      r = sda_in;
      w(1);
      scl_out = 1'b0;
   endtask
   // Eight bits then a ninth; q[0] is the wire seen on the ninth
   task automatic xfer(input logic [7:0] d, input logic nine, output logic [8:0] q);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i+1]);
      end
      bit_io(nine, q[0]);
   endtask
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
   localparam logic [6:0] DEV = 7'h00;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic m_scl, m_sda, sda_w, sda_oe, sda_o;
   logic sleep, unl, rdy, rawv, fullv;
   logic [8:0] q;
   hsi_pkg::hsi_read_s rd_in = {12'habc, 12'hf03};
   int failures = 0;
   int samples_checked = 0;
   int wake_cnt = 0;
   always #20 clk = ~clk;
   // Open-drain wire with pull-up
   assign sda_w = m_sda & ~sda_oe;
   always @(posedge clk) wake_cnt <= (sleep === 1'b0) ? wake_cnt + 1 : 0;
   hsi_i2c_slave #(.DEV_ADDR(DEV), .CLK_MHZ(1)) DUT (
      .clock_in(clk), .rst_n_in(rst_n), .clk_en_in(1'b1), .scl_in(m_scl),
      .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe), .reading_in(rd_in),
      .sleep_out(sleep), .unlocked_out(unl), .ready_out(rdy),
      .raw_valid_out(rawv), .full_valid_out(fullv));
   hsi_mst_model u_mst (.clk_in(clk), .sda_in(sda_w), .scl_out(m_scl), .sda_out(m_sda));
   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic done(input string n);
      $display("test %0s done", n);
   endtask
   task automatic wr_head(input logic [7:0] ra);
      u_mst.start();
      u_mst.xfer({DEV, 1'b0}, 1'b1, q);
      `CHK("addr_ack", 1'b0, q[0])
      u_mst.xfer(ra, 1'b1, q);
      `CHK("reg_ack", 1'b0, q[0])
   endtask
   task automatic wr_word(input logic [31:0] d);
      for (int i = 3; i >= 0; i--) begin
         u_mst.xfer(d[8*i +: 8], 1'b1, q);
         `CHK("data_ack", 1'b0, q[0])
      end
   endtask
   task automatic rd_head(input logic [7:0] ra);
      wr_head(ra);
      u_mst.start();
      u_mst.xfer({DEV, 1'b1}, 1'b1, q);
      `CHK("rd_ack", 1'b0, q[0])
   endtask
   // Master acknowledges all but the final byte
   task automatic rd_word(input logic [31:0] e, input logic last);
      logic [31:0] g;
      for (int i = 3; i >= 0; i--) begin
         u_mst.xfer(8'hff, last && i == 0, q);
         g[8*i +: 8] = q[8:1];
      end
      `CHK("rd_word", e, g)
   endtask
   task automatic set_sleep(input logic s);
      wr_head(8'h20);
      wr_word({31'h0, s});
      u_mst.stop();
   endtask
   // Cycle counts from sleep release to each milestone
   task automatic wake_chk();
      int tr;
      int tw;
      tr = 0;
      tw = 0;
      for (int i = 0; i < 700 && fullv !== 1'b1; i++) begin
         @(negedge clk);
         if (rdy === 1'b1 && tr == 0) tr = wake_cnt;
         if (rawv === 1'b1 && tw == 0) tw = wake_cnt;
      end
      // A wake that never completes ends the run at once
      if (fullv !== 1'b1) begin
         failures++;
         $display("BAD wake_timeout exp 1 got %b", fullv);
         stop_test();
      end else begin
         `CHK("t_ready", 1'b1, tr inside {[44:58]})
         `CHK("t_raw", 1'b1, tw inside {[144:158]})
         `CHK("t_full", 1'b1, wake_cnt inside {[494:508]})
      end
   endtask
   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      `CHK("sleep_rst", 1'b0, sleep)
      `CHK("unl_rst", 1'b0, unl)
      done("reset");
      rd_head(8'h1f);
      rd_word(32'h00000abc, 1'b0);
      rd_word(32'h00000000, 1'b1);
      u_mst.stop();
      rd_head(8'h1d);
      rd_word(32'h00000f03, 1'b1);
      u_mst.stop();
      done("read");
      // Restart in mid-register, then a foreign address
      wr_head(8'h20);
      // Only three of four bytes, so the sleep byte never lands
      for (int i = 0; i < 3; i++) begin
         u_mst.xfer(8'hff, 1'b1, q);
         `CHK("part_ack", 1'b0, q[0])
      end
      u_mst.start();
      u_mst.xfer({7'h55, 1'b0}, 1'b1, q);
      `CHK("foreign_ack", 1'b1, q[0])
      u_mst.stop();
      `CHK("abort_sleep", 1'b0, sleep)
      done("abort");
      wr_head(8'h24);
      wr_word(32'h2c413535);
      u_mst.stop();
      `CHK("bad_key", 1'b0, unl)
      wr_head(8'h1f);
      wr_word(32'h00000fff);
      wr_word(32'h00000001);
      u_mst.stop();
      `CHK("auto_inc", 1'b1, sleep)
      `CHK("asleep", 1'b0, rawv)
      set_sleep(1'b0);
      wake_chk();
      rd_head(8'h1f);
      rd_word(32'h00000abc, 1'b0);
      rd_word(32'h00000000, 1'b1);
      u_mst.stop();
      done("sleep");
      wr_head(8'h24);
      wr_word(32'h2c413534);
      u_mst.stop();
      `CHK("unlock", 1'b1, unl)
      set_sleep(1'b1);
      set_sleep(1'b0);
      wake_chk();
      `CHK("unl_kept", 1'b1, unl)
      done("unlock");
      stop_test();
   end
endmodule
bind hsi_i2c_slave hsi_chk #(.CLK_MHZ(CLK_MHZ)) u_chk (
   .clock_in(clock_in), .rst_n_in(rst_n_in), .scl_in(scl_in), .sda_out(sda_out),
   .sda_oe_out(sda_oe_out), .sleep_out(sleep_out), .unlocked_out(unlocked_out),
   .ready_out(ready_out), .raw_valid_out(raw_valid_out), .full_valid_out(full_valid_out));
